// [verilog/pclt_pkg.sv]
/*
  shared constants, enumerations and carriers of the logic-equation block:
  register map, equation opcodes, operand layout, time base and comparator settings.
  assumes one 25 MHz processing clock and 32-bit APB data.
*/
package pclt_pkg;
  // ==========================================================
  // sizes
  localparam int EQ_N = 512;
  localparam int NTMR = 32;
  localparam int NLAT = 16;
  localparam int NCMP = 8;
  localparam int NANA = 16;
  localparam int NEXT = 32;
  localparam int NVO  = 64;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] A_CTRL = 12'h000; // run enable
  localparam logic [11:0] A_STAT = 12'h004; // pass count, position, busy
  localparam logic [11:0] A_LTYP = 12'h008; // latch type, 1 = set dominant
  localparam logic [11:0] A_LST  = 12'h00c; // latch state, read only
  localparam logic [11:0] A_TMR  = 12'h100; // 2 words per timer
  localparam logic [11:0] A_CMP  = 12'h400; // 4 words per comparator
  localparam logic [11:0] A_EQ   = 12'h800; // one word per equation entry
  localparam logic [31:0] CTRL_DEF = 32'h0000_0001;
  localparam logic [31:0] CW0_DEF  = 32'h0000_0000;      // disabled, inputs off
  localparam logic [31:0] CW1_DEF  = 32'h01e0_03e8;      // 3.0 % band, 1.000 pu
  localparam logic [31:0] CW2_DEF  = 32'h0000_0014;      // interval 20
  localparam logic [31:0] CW3_DEF  = 32'h0000_0000;      // no delays
  // ==========================================================
  // equation opcodes, entry = {op[15:12], 4'h0, arg[7:0]}
  localparam logic [3:0] OP_END  = 4'h0;
  localparam logic [3:0] OP_PUSH = 4'h1;
  localparam logic [3:0] OP_NOT  = 4'h2;
  localparam logic [3:0] OP_AND  = 4'h3;
  localparam logic [3:0] OP_OR   = 4'h4;
  localparam logic [3:0] OP_XOR  = 4'h5;
  localparam logic [3:0] OP_TMR  = 4'h6;
  localparam logic [3:0] OP_LAT  = 4'h7;
  localparam logic [3:0] OP_ASG  = 4'h8;
  localparam logic [15:0] EQ_DEF = 16'h0000;
  // operand vector bases
  localparam int OB_ON = 1;
  localparam int OB_EXT = 8;
  localparam int OB_VO = 64;
  localparam int OB_TMR = 128;
  localparam int OB_LON = 160;
  localparam int OB_LOFF = 176;
  localparam int OB_CPK = 192;
  localparam int OB_COP = 200;
  // ==========================================================
  // time base
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 40;
  localparam int CYC_MS = MS_NS / CLK_NS;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int HYST_DIV = 1000;         // band in tenths of a percent
  // ==========================================================
  // types
  typedef enum logic [1:0] {U_MS = 2'h0, U_S = 2'h1, U_MIN = 2'h2} pclt_unit_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EVAL = 2'b01, ST_DONE = 2'b11} pclt_st_t;
  typedef struct packed {
    logic [3:0]         kind;
    logic signed [31:0] val;            // milli per-unit
  } pclt_ana_t;
  typedef struct packed {
    logic               en;
    logic [4:0]         pos;            // 0 = off, n = analog input n-1
    logic [4:0]         neg;
    logic               absm;
    logic               delta;
    logic               under;
    logic [1:0]         unit;
    logic [7:0]         block_operand;
    logic [9:0]         hyst;
    logic signed [17:0] pkp;
    logic [16:0]        rate_interval;
    logic [15:0]        pickup_delay_setting;
    logic [15:0]        rst_dly;
  } pclt_cmp_t;
endpackage : pclt_pkg

// [verilog/pclt_top.sv]
/*
  equation evaluator with 512-entry table, 32 timers, analog comparators and 16
  latches behind an APB slave.
  assumes analog values arrive already scaled in milli per-unit and synchronous
  to pclk; latch state is kept by outside non-volatile storage via nv_image.
*/
// Overview of operation
// - 512-entry table, all entries default end
// - disabled element flag stays zero
// - 32 identical timers usable as operators
// - pickup and dropout delays, zero means none
// - timer type selects counting time unit
// - operating signal is plus minus minus
// - both inputs off asserts nothing
// - mismatched input kinds block operation
// - signed uses signal, absolute uses magnitude
// - level uses signal, delta uses interval change
// - over picks above, under picks below
// - hysteresis band percent of pickup
// - signed pickup threshold in milli per-unit
// - rate interval and unit only in delta
// - separate pickup and reset delays
// - latch state survives reset via storage
// - 16 latches, true and complement, hold
// - reset dominant: reset wins
// - set dominant: set wins
// - table from entry 0 evaluated often, in order
// - pass stops at first end entry
`timescale 1ns/1ns
// ==========================================================
// delay element shared by timers and comparators
module pclt_dly (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        d,
  input  wire logic [16:0] pdly,
  input  wire logic [16:0] rdly,
  output logic             q
);
  logic [16:0] cnt_ff;
  wire  [16:0] dly = d ? pdly : rdly;
  // count ticks while input differs from output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 17'h0;
      q      <= 1'b0;
    end else if (d == q) begin
      cnt_ff <= 17'h0;
    end else if (dly == 17'h0) begin
      q <= d;
    end else if (tick) begin
      if (cnt_ff + 17'h1 >= dly) begin
        q      <= d;
        cnt_ff <= 17'h0;
      end else begin
        cnt_ff <= cnt_ff + 17'h1;
      end
    end
  end
  a_dly_zero:
    assert property (@(posedge pclk) disable iff (!presetn)
      (d && !q && pdly == 17'h0) |=> q)
    else $error("zero pickup delay did not pass at once");
endmodule : pclt_dly

`timescale 1ns/1ns
module pclt_top #(
  parameter int CYC_PER_MS = pclt_pkg::CYC_MS
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic [11:0]                     paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [pclt_pkg::NEXT-1:0]       ext_in,
  input  wire pclt_pkg::pclt_ana_t [pclt_pkg::NANA-1:0] ana_in,
  input  wire logic [pclt_pkg::NLAT-1:0]       nv_image,
  output logic [pclt_pkg::NVO-1:0]             virt_out,
  output logic [pclt_pkg::NTMR-1:0]            timer_out,
  output logic [pclt_pkg::NLAT-1:0]            latch_on,
  output logic [pclt_pkg::NLAT-1:0]            latch_off,
  output logic [pclt_pkg::NCMP-1:0]            cmp_pkp,
  output logic [pclt_pkg::NCMP-1:0]            cmp_op,
  output logic                                 pass_done
);
  import pclt_pkg::*;
  // ==========================================================
  // settings storage
  logic [15:0]     eq_ff [EQ_N];
  logic [31:0]     tmr_w_ff [NTMR*2];
  logic [31:0]     cmp_w_ff [NCMP*4];
  logic [31:0]     ctrl_ff;
  logic [NLAT-1:0] ltyp_ff;
  logic [NLAT-1:0] latch_q_ff;
  logic            loaded_ff;
  logic [31:0]     prdata_ff;
  logic            perr_ff;
  logic [15:0]     pass_cnt_ff;
  // ==========================================================
  // apb decode
  wire hit_eq   = paddr[11];
  wire hit_cmp  = paddr[11:7] == A_CMP[11:7];
  wire hit_tmr  = paddr[11:8] == A_TMR[11:8];
  wire hit_ctrl = paddr == A_CTRL;
  wire hit_stat = paddr == A_STAT;
  wire hit_ltyp = paddr == A_LTYP;
  wire hit_lst  = paddr == A_LST;
  wire hit_any  = hit_eq | hit_cmp | hit_tmr | hit_ctrl | hit_stat | hit_ltyp | hit_lst;
  wire wr_en    = psel & penable & pwrite & (paddr[1:0] == 2'h0);
  wire setup    = psel & ~penable;
  wire [8:0] eq_idx  = paddr[10:2];
  wire [5:0] tmr_idx = paddr[7:2];
  wire [4:0] cmp_idx = paddr[6:2];
  pclt_st_t st_ff;
  logic [8:0] pc_ff;
  wire [31:0] rd_data =
    hit_eq   ? {16'h0, eq_ff[eq_idx]} :
    hit_cmp  ? cmp_w_ff[cmp_idx] :
    hit_tmr  ? tmr_w_ff[tmr_idx] :
    hit_ctrl ? ctrl_ff :
    hit_stat ? {6'h0, st_ff != ST_IDLE, pc_ff, pass_cnt_ff} :
    hit_ltyp ? {16'h0, ltyp_ff} :
    hit_lst  ? {16'h0, latch_q_ff} : 32'h0;
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = perr_ff & psel & penable;
  // read data and error captured in the setup cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      perr_ff   <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0 : rd_data;
      perr_ff   <= ~hit_any | hit_stat & pwrite | hit_lst & pwrite;
    end
  end
  // register writes; table entries default to end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EQ_N; i++) eq_ff[i] <= EQ_DEF;
      for (int i = 0; i < NTMR*2; i++) tmr_w_ff[i] <= 32'h0;
      for (int i = 0; i < NCMP; i++) begin
        cmp_w_ff[4*i]   <= CW0_DEF;
        cmp_w_ff[4*i+1] <= CW1_DEF;
        cmp_w_ff[4*i+2] <= CW2_DEF;
        cmp_w_ff[4*i+3] <= CW3_DEF;
      end
      ctrl_ff <= CTRL_DEF;
      ltyp_ff <= '0;
    end else if (wr_en) begin
      if (hit_eq) eq_ff[eq_idx] <= pwdata[15:0];
      if (hit_cmp) cmp_w_ff[cmp_idx] <= pwdata;
      if (hit_tmr) tmr_w_ff[tmr_idx] <= pwdata;
      if (hit_ctrl) ctrl_ff <= {31'h0, pwdata[0]};
      if (hit_ltyp) ltyp_ff <= pwdata[15:0];
    end
  end
  // ==========================================================
  // common time base: ms, s, min ticks
  logic [$clog2(CYC_PER_MS)-1:0] pre_ff;
  logic [9:0] ms_ff;
  logic [5:0] s_ff;
  logic [2:0] tick;
  wire ms_tk  = pre_ff == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1);
  wire s_tk   = ms_tk & (ms_ff == 10'(MS_PER_S - 1));
  wire min_tk = s_tk & (s_ff == 6'(S_PER_MIN - 1));
  assign tick = {min_tk, s_tk, ms_tk};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= '0;
      ms_ff  <= 10'h0;
      s_ff   <= 6'h0;
    end else begin
      pre_ff <= ms_tk ? '0 : pre_ff + 1'b1;
      if (ms_tk) ms_ff <= s_tk ? 10'h0 : ms_ff + 10'h1;
      if (s_tk) s_ff <= min_tk ? 6'h0 : s_ff + 6'h1;
    end
  end
  function automatic logic unit_tick(input logic [1:0] u, input logic [2:0] t);
    unit_tick = (u == U_S) ? t[1] : (u == U_MIN) ? t[2] : t[0];
  endfunction : unit_tick
  // ==========================================================
  // operand vector seen by the equations and block settings
  logic [255:0] opv;
  logic [NTMR-1:0] tmr_in_ff;
  logic [NVO-1:0] vo_ff;
  always_comb begin
    opv = '0;
    opv[OB_ON] = 1'b1;
    opv[OB_EXT +: NEXT] = ext_in;
    opv[OB_VO +: NVO] = vo_ff;
    opv[OB_TMR +: NTMR] = timer_out;
    opv[OB_LON +: NLAT] = latch_q_ff;
    opv[OB_LOFF +: NLAT] = ~latch_q_ff;
    opv[OB_CPK +: NCMP] = cmp_pkp;
    opv[OB_COP +: NCMP] = cmp_op;
  end
  // ==========================================================
  // timers
  for (genvar t = 0; t < NTMR; t++) begin : g_tmr
    pclt_dly u_dly (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (unit_tick(tmr_w_ff[2*t+1][1:0], tick)),
      .d       (tmr_in_ff[t]),
      .pdly    ({1'b0, tmr_w_ff[2*t][15:0]}),
      .rdly    ({1'b0, tmr_w_ff[2*t][31:16]}),
      .q       (timer_out[t])
    );
  end
  // ==========================================================
  // comparators
  function automatic pclt_cmp_t cmp_dec(input logic [31:0] w0, w1, w2, w3);
    pclt_cmp_t c;
    c.en = w0[0];
    c.pos = w0[5:1];
    c.neg = w0[10:6];
    c.absm = w0[11];
    c.delta = w0[12];
    c.under = w0[13];
    c.unit = w0[15:14];
    c.block_operand = w0[23:16];
    c.hyst = w1[29:20];
    c.pkp = w1[17:0];
    c.rate_interval = w2[16:0];
    c.pickup_delay_setting = w3[15:0];
    c.rst_dly = w3[31:16];
    return c;
  endfunction : cmp_dec
  logic [NCMP-1:0] cmp_st_ff;
  logic [NCMP-1:0] cmp_bad;
  for (genvar c = 0; c < NCMP; c++) begin : g_cmp
    pclt_cmp_t cf;
    logic signed [32:0] hold_ff;
    logic [16:0] dt_cnt_ff;
    assign cf = cmp_dec(cmp_w_ff[4*c], cmp_w_ff[4*c+1], cmp_w_ff[4*c+2], cmp_w_ff[4*c+3]);
    wire pon = cf.pos != 5'h0;
    wire non = cf.neg != 5'h0;
    wire pclt_ana_t pa = ana_in[4'(cf.pos - 5'h1)];
    wire pclt_ana_t na = ana_in[4'(cf.neg - 5'h1)];
    wire signed [32:0] a = pon ? 33'(pa.val) : 33'sh0;
    wire signed [32:0] b = non ? 33'(na.val) : 33'sh0;
    wire signed [32:0] diff = a - b;
    wire signed [32:0] opsig = (cf.absm && diff < 0) ? -diff : diff;
    wire signed [33:0] sig = cf.delta ? 34'(opsig) - 34'(hold_ff) : 34'(opsig);
    wire signed [33:0] pk = 34'(cf.pkp);
    wire [17:0] pk_mag = cf.pkp < 0 ? 18'(-cf.pkp) : 18'(cf.pkp);
    wire [27:0] band_w = 28'(pk_mag) * 28'(cf.hyst) / 28'(HYST_DIV);
    wire signed [33:0] band = 34'(band_w);
    wire mism = pon & non & (pa.kind != na.kind);
    assign cmp_bad[c] = ~cf.en | ~(pon | non) | mism | opv[cf.block_operand];
    wire pick = cf.under ? (sig < pk) : (sig > pk);
    wire keep = cf.under ? (sig <= pk + band) : (sig >= pk - band);
    wire dt_end = dt_cnt_ff + 17'h1 >= cf.rate_interval;
    // rate interval: sample the operating signal once per interval
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hold_ff   <= 33'sh0;
        dt_cnt_ff <= 17'h0;
      end else if (!cf.delta) begin
        hold_ff   <= opsig;
        dt_cnt_ff <= 17'h0;
      end else if (unit_tick(cf.unit, tick)) begin
        dt_cnt_ff <= dt_end ? 17'h0 : dt_cnt_ff + 17'h1;
        if (dt_end) hold_ff <= opsig;
      end
    end
    // pickup state with hysteresis dropout
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cmp_st_ff[c] <= 1'b0;
      else cmp_st_ff[c] <= ~cmp_bad[c] & (cmp_st_ff[c] ? keep : pick);
    end
    pclt_dly u_cdly (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick[0]),
      .d       (cmp_st_ff[c] & ~cmp_bad[c]),
      .pdly    ({1'b0, cf.pickup_delay_setting}),
      .rdly    ({1'b0, cf.rst_dly}),
      .q       (cmp_op[c])
    );
  end
  assign cmp_pkp = cmp_st_ff;
  // ==========================================================
  // sequential equation engine, one entry per clock
  logic [7:0] stk_ff;
  wire [15:0] ent    = eq_ff[pc_ff];
  wire [3:0]  cur_op = ent[15:12];
  wire [7:0]  arg    = ent[7:0];
  wire s0 = stk_ff[0];
  wire s1 = stk_ff[1];
  wire run = ctrl_ff[0] & loaded_ff;
  wire in_eval = st_ff == ST_EVAL;
  wire lat_ev = in_eval & (cur_op == OP_LAT);
  wire [3:0] lidx = arg[3:0];
  wire lat_nxt = (ltyp_ff[lidx] | ~s0) ? (s1 | latch_q_ff[lidx] & ~s0) : 1'b0;
  wire last = (cur_op == OP_END) | (pc_ff == 9'(EQ_N - 1));
  logic [7:0] nxt_stk;
  always_comb begin
    case (cur_op)
      OP_PUSH: nxt_stk = {stk_ff[6:0], opv[arg]};
      OP_NOT:  nxt_stk = {stk_ff[7:1], ~s0};
      OP_AND:  nxt_stk = {1'b0, stk_ff[7:2], s0 & s1};
      OP_OR:   nxt_stk = {1'b0, stk_ff[7:2], s0 | s1};
      OP_XOR:  nxt_stk = {1'b0, stk_ff[7:2], s0 ^ s1};
      OP_TMR:  nxt_stk = {stk_ff[7:1], timer_out[arg[4:0]]};
      OP_LAT:  nxt_stk = {1'b0, stk_ff[7:2], lat_nxt};
      OP_ASG:  nxt_stk = {1'b0, stk_ff[7:1]};
      default: nxt_stk = stk_ff;
    endcase
  end
  // pass control: restart immediately after each pass while run is enabled, else go idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff       <= ST_IDLE;
      pc_ff       <= 9'h0;
      stk_ff      <= 8'h0;
      pass_cnt_ff <= 16'h0;
      pass_done   <= 1'b0;
    end else begin
      pass_done <= 1'b0;
      case (st_ff)
        ST_IDLE: if (run) st_ff <= ST_EVAL;
        ST_EVAL: begin
          stk_ff <= nxt_stk;
          pc_ff  <= pc_ff + 9'h1;
          if (last) st_ff <= ST_DONE;
        end
        ST_DONE: begin
          pc_ff       <= 9'h0;
          stk_ff      <= 8'h0;
          pass_done   <= 1'b1;
          pass_cnt_ff <= pass_cnt_ff + 16'h1;
          st_ff       <= run ? ST_EVAL : ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  // operator side effects: timer inputs and virtual outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_in_ff <= '0;
      vo_ff     <= '0;
    end else if (in_eval) begin
      if (cur_op == OP_TMR) tmr_in_ff[arg[4:0]] <= s0;
      if (cur_op == OP_ASG) vo_ff[arg[5:0]] <= s0;
    end
  end
  // ==========================================================
  // latches: restored from storage image after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q_ff <= '0;
      loaded_ff  <= 1'b0;
    end else if (!loaded_ff) begin
      latch_q_ff <= nv_image;
      loaded_ff  <= 1'b1;
    end else if (lat_ev) begin
      latch_q_ff[lidx] <= lat_nxt;
    end
  end
  assign latch_on  = latch_q_ff;
  assign latch_off = ~latch_q_ff;
  assign virt_out  = vo_ff;
  // ==========================================================
  // checks
  a_end_stop:
    assert property (@(posedge pclk) disable iff (!presetn)
      (in_eval && cur_op == OP_END) |=> st_ff == ST_DONE ##1 pc_ff == 9'h0)
    else $error("pass did not stop at end entry");
  a_pass_bound:
    assert property (@(posedge pclk) disable iff (!presetn)
      (in_eval && pc_ff == 9'h0) |-> ##[1:513] st_ff == ST_DONE)
    else $error("pass took longer than the table");
  a_latch_rdom:
    assert property (@(posedge pclk) disable iff (!presetn)
      (lat_ev && s0 && !ltyp_ff[lidx]) |=> !latch_q_ff[$past(lidx)])
    else $error("reset dominant latch not cleared");
  a_latch_sdom:
    assert property (@(posedge pclk) disable iff (!presetn)
      (lat_ev && s1 && ltyp_ff[lidx]) |=> latch_on[$past(lidx)] && !latch_off[$past(lidx)])
    else $error("set dominant latch not set");
  a_latch_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      (lat_ev && !s0 && !s1) |=> latch_q_ff == $past(latch_q_ff))
    else $error("latch changed without set or reset");
  a_cmp_nosel:
    assert property (@(posedge pclk) disable iff (!presetn)
      (cmp_w_ff[0][10:1] == 10'h0) [*2] |-> !cmp_pkp[0])
    else $error("comparator picked up with no inputs");
  a_cmp_disab:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!cmp_w_ff[0][0]) [*2] |-> !cmp_pkp[0])
    else $error("disabled comparator flag set");
  a_apb_unmap:
    assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !hit_any) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : pclt_top

// [tb/test_pclt_top.sv]
/*
  random and directed bench of the equation block over apb.
  assumes a 25 mhz pclk, CYC_PER_MS of 4 and the block's package constants.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_pclt_top;
  import pclt_pkg::*;
  localparam logic [15:0] PROG [23] = '{
    {OP_PUSH, 12'h008}, {OP_NOT, 12'h0}, {OP_ASG, 12'h000}, {OP_PUSH, 12'h009},
    {OP_PUSH, 12'h00a}, {OP_LAT, 12'h0}, {OP_ASG, 12'h001}, {OP_PUSH, 12'h00b},
    {OP_TMR, 12'h01f}, {OP_ASG, 12'h002}, {OP_PUSH, 12'h009}, {OP_PUSH, 12'h008},
    {OP_AND, 12'h0}, {OP_ASG, 12'h003}, {OP_PUSH, 12'h009}, {OP_PUSH, 12'h00a},
    {OP_XOR, 12'h0}, {OP_PUSH, 12'h008}, {OP_OR, 12'h0}, {OP_ASG, 12'h005},
    {OP_END, 12'h0}, {OP_PUSH, 12'h001}, {OP_ASG, 12'h004}};
  int          cw [12] = '{3, 3, 3, 'h2003, 2, 1, 3, 'h83, 'h83, 'h803, 'h1003, 'h10003};
  int          pk [12] = '{1000, 1000, 1000, 1000, 1000, 1000, -500, 1000,
                           1000, 1000, 1000, 1000};
  int          v0 [12] = '{1500, 980, 960, 500, 1500, 1500, -200, 1500, 2000, -1500, 1500,
                           1500};
  int          v1 [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1500, 0, 0, 0};
  logic [3:0]  k1 [12] = '{1, 1, 1, 1, 1, 1, 1, 2, 1, 1, 1, 1};
  logic        ex [12] = '{1, 1, 0, 1, 0, 0, 1, 0, 0, 1, 0, 0};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pass_done, err, lq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NEXT-1:0]      ext_in;
  pclt_ana_t [NANA-1:0] ana_in;
  logic [NLAT-1:0]      nv_image, latch_on, latch_off;
  logic [NVO-1:0]       virt_out;
  logic [NTMR-1:0]      timer_out;
  logic [NCMP-1:0]      cmp_pkp, cmp_op;
  int          errors, tests_run;

  pclt_top #(.CYC_PER_MS(4)) u_pclt_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_in(ext_in), .ana_in(ana_in),
    .nv_image(nv_image), .virt_out(virt_out), .timer_out(timer_out),
    .latch_on(latch_on), .latch_off(latch_off), .cmp_pkp(cmp_pkp), .cmp_op(cmp_op),
    .pass_done(pass_done));

  // ==========================================================
  // clock and helpers
  always #20 pclk = ~pclk;

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // wait for k completed passes, ending at a falling edge for sampling
  task automatic passes(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin
        @(negedge pclk);
        n++;
      end while (pass_done !== 1'b1 && n < 5000);
    end
    if (n >= 5000) errors++;
  endtask : passes

  // expected latch state for type d (1 = set dominant)
  function automatic logic lat(input logic d, input logic s, input logic r, input logic q);
    if (s & r) return d;
    if (s | r) return s;
    return q;
  endfunction : lat

  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // watchdog well beyond the expected run length
  initial begin
    #1600000;
    errors++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ext_in = 0; ana_in = '0; errors = 0; tests_run = 0;
    void'($urandom(32'h3a72));
    nv_image = 16'($urandom);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(latch_on, nv_image)
    `CHK(latch_off, ~nv_image)
    // reset values and an unmapped place
    apb(0, A_EQ + 12'h7fc, 0); `CHK(rd[15:0], EQ_DEF)
    apb(0, A_EQ + 12'(4 * ($urandom % 511)), 0); `CHK(rd[15:0], EQ_DEF)
    apb(0, A_CMP + 12'h4, 0); `CHK(rd, CW1_DEF)
    apb(0, A_CMP + 12'h8, 0); `CHK(rd, CW2_DEF)
    apb(0, 12'h0f0, 0); `CHK(err, 1'b1)
    for (int i = 0; i < 23; i++) apb(1, A_EQ + 12'(4 * i), {16'h0, PROG[i]});
    // random operands through logic, latch and end entry, both latch types
    lq = nv_image[0];
    for (int t = 0; t < 2; t++) begin
      apb(1, A_LTYP, 32'(t));
      lq = lat(t[0], ext_in[1], ext_in[2], lq);
      repeat (16) begin
        ext_in <= $urandom & 32'hffff_fff7;
        @(posedge pclk);
        passes(3);
        lq = lat(t[0], ext_in[1], ext_in[2], lq);
        `CHK(virt_out[0], ~ext_in[0])
        `CHK(virt_out[3], ext_in[0] & ext_in[1])
        `CHK(virt_out[5], (ext_in[1] ^ ext_in[2]) | ext_in[0])
        `CHK(virt_out[4], 1'b0)
        `CHK({latch_on[0], virt_out[1]}, {lq, lq})
        `CHK(latch_off[0], ~lq)
        `CHK(latch_on[15:1], nv_image[15:1])
        @(posedge pclk);
      end
    end
    // last timer: 3 ms pickup, no dropout, then 2 s pickup (tick phase unknown)
    apb(1, A_TMR + 12'hf8, 32'h0000_0003);
    ext_in <= ext_in | 32'h8;
    repeat (6) @(posedge pclk);
    `CHK(timer_out[31], 1'b0)
    passes(4); `CHK(timer_out[31], 1'b1)
    `CHK(virt_out[2], 1'b1)
    @(posedge pclk);
    ext_in <= ext_in & 32'hffff_fff7;
    passes(2); `CHK(timer_out[31], 1'b0)
    @(posedge pclk);
    apb(1, A_TMR + 12'hfc, 32'h1);
    apb(1, A_TMR + 12'hf8, 32'h2);
    ext_in <= ext_in | 32'h8;
    repeat (2000) @(posedge pclk);
    `CHK(timer_out[31], 1'b0)
    repeat (6200) @(posedge pclk);
    `CHK(timer_out[31], 1'b1)
    // comparator cases, hysteresis band of 3.0 percent
    ana_in[0].kind <= 4'h1;
    for (int i = 0; i < 12; i++) begin
      apb(1, A_CMP + 12'h4, {12'h01e, 2'b0, 18'(pk[i])});
      apb(1, A_CMP, 32'(cw[i]));
      ana_in[0].val <= v0[i];
      ana_in[1].val <= v1[i];
      ana_in[1].kind <= k1[i];
      passes(3);
      if (i == 10) repeat (300) @(negedge pclk);
      `CHK(cmp_pkp[0], ex[i])
      `CHK(cmp_op[0], ex[i])
      @(posedge pclk);
    end
    // 5 ms pickup delay on the operate output
    apb(1, A_CMP + 12'hc, 32'h0000_0005);
    apb(1, A_CMP, 32'h3);
    repeat (8) @(posedge pclk);
    `CHK({cmp_pkp[0], cmp_op[0]}, 2'b10)
    repeat (60) @(posedge pclk);
    `CHK(cmp_op[0], 1'b1)
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({cmp_pkp[0], cmp_op[0], timer_out[31]}, 3'b000)
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(latch_on, nv_image)
    end_sim();
  end
endmodule : test_pclt_top
